// *** nvsram_host.sv ***
// Host controller driving an 8K x 8 non-volatile SRAM through its pins
// Operation
// - Store needs six ordered reads, exact addresses
// - Write enable stays high through sequence
// - Address stable across whole write
// - Output enable kept high during writes
// - Write enable is last to reach store
// - Address frozen during software recall
// - Started sequence completes before restarting
`timescale 1ns/1ps
module nvsram_host #(
    parameter int STORE_WAIT_CYC = nvsram_host_pkg::STORE_CYC
) (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    input  wire logic                                 ce,
    input  wire logic                                 hw_variant,
    input  wire logic                                 cmd_valid,
    input  wire nvsram_host_pkg::cmd_type             cmd,
    output logic                                      cmd_ready,
    output logic                                      resp_valid,
    output nvsram_host_pkg::resp_type                 resp,
    output nvsram_host_pkg::ctl_pins_type             pins,
    output logic [nvsram_host_pkg::ADDR_W-1:0]        address_lines,
    output logic [nvsram_host_pkg::DATA_W-1:0]        data_lines_out,
    output logic                                      data_lines_oe,
    input  wire logic [nvsram_host_pkg::DATA_W-1:0]   data_lines_in,
    input  wire logic                                 supply_low
);
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RELEASE,
        ST_NV_WAIT
    } state_type;

    state_type                            state_ff, nxt_state;
    nvsram_host_pkg::cmd_type             cmd_ff, nxt_cmd;
    nvsram_host_pkg::ctl_pins_type        ctl_ff, nxt_ctl;
    nvsram_host_pkg::resp_type            resp_ff, nxt_resp;
    logic [nvsram_host_pkg::ADDR_W-1:0]   addr_ff, nxt_addr;
    logic [nvsram_host_pkg::DATA_W-1:0]   dout_ff, nxt_dout;
    logic                                 doe_ff, nxt_doe;
    logic                                 resp_valid_ff, nxt_resp_valid;
    logic [2:0]                           idx_ff, nxt_idx;
    logic [nvsram_host_pkg::DATA_W-1:0]   din_meta_ff, din_sync_ff;
    logic                                 low_meta_ff, low_sync_ff;
    logic                                 tmr_load;
    logic [nvsram_host_pkg::TIMER_W-1:0]  tmr_value;
    logic                                 tmr_done;

    // Pin levels for the first and second phase of each operation
    function automatic nvsram_host_pkg::ctl_pins_type setup_pins(
        input nvsram_host_pkg::op_type op);
        setup_pins = nvsram_host_pkg::PINS_IDLE;
        if (op == nvsram_host_pkg::OP_PIN_STORE || op == nvsram_host_pkg::OP_PIN_RECALL) begin
            setup_pins.chip_en_low             = 1'b0;
            setup_pins.nonvolatile_trigger_low = 1'b0;
        end
    endfunction

    function automatic nvsram_host_pkg::ctl_pins_type strobe_pins(
        input nvsram_host_pkg::op_type op);
        strobe_pins = setup_pins(op);
        strobe_pins.chip_en_low = 1'b0;
        case (op)
            nvsram_host_pkg::OP_WRITE:      strobe_pins.write_en_low = 1'b0;
            nvsram_host_pkg::OP_PIN_STORE:  strobe_pins.write_en_low = 1'b0;
            default:                        strobe_pins.out_en_low   = 1'b0;
        endcase
    endfunction

    wire nvsram_host_pkg::op_type cur_op    = cmd_ff.op;
    wire                          cur_sw    = nvsram_host_pkg::is_sw(cur_op);
    wire                          cur_rcl   = (cur_op == nvsram_host_pkg::OP_SW_RECALL) ||
                                              (cur_op == nvsram_host_pkg::OP_PIN_RECALL);
    wire                          new_sw    = nvsram_host_pkg::is_sw(cmd.op);
    wire                          new_pin   = (cmd.op == nvsram_host_pkg::OP_PIN_STORE) ||
                                              (cmd.op == nvsram_host_pkg::OP_PIN_RECALL);
    wire                          refuse    = (nvsram_host_pkg::is_store(cmd.op) && low_sync_ff)
                                              || (new_sw && hw_variant)
                                              || (new_pin && !hw_variant);
    wire [nvsram_host_pkg::ADDR_W-1:0] start_addr = new_sw ?
        nvsram_host_pkg::SEQ_ADDR_0 : cmd.addr;
    wire [nvsram_host_pkg::ADDR_W-1:0] next_seq_addr =
        nvsram_host_pkg::seq_addr(idx_ff + 3'h1, cur_rcl);
    wire                          seq_more  = cur_sw && (idx_ff != 3'(nvsram_host_pkg::SEQ_LAST));
    wire                          nv_op     = cur_op != nvsram_host_pkg::OP_READ &&
                                              cur_op != nvsram_host_pkg::OP_WRITE;
    wire [nvsram_host_pkg::TIMER_W-1:0] strobe_len =
        (cur_op == nvsram_host_pkg::OP_PIN_RECALL) ?
            nvsram_host_pkg::TIMER_W'(nvsram_host_pkg::RECALL_INIT_CYC - 1) :
        (cur_op == nvsram_host_pkg::OP_WRITE || cur_op == nvsram_host_pkg::OP_PIN_STORE) ?
            nvsram_host_pkg::TIMER_W'(nvsram_host_pkg::PULSE_CYC - 1) :
            nvsram_host_pkg::TIMER_W'(nvsram_host_pkg::READ_CYC - 1);
    wire [nvsram_host_pkg::TIMER_W-1:0] nv_len = cur_rcl ?
        nvsram_host_pkg::TIMER_W'(nvsram_host_pkg::RECALL_CYC - 1) :
        nvsram_host_pkg::TIMER_W'(STORE_WAIT_CYC - 1);

    always_comb begin
        nxt_state      = state_ff;
        nxt_cmd        = cmd_ff;
        nxt_ctl        = ctl_ff;
        nxt_resp       = resp_ff;
        nxt_addr       = addr_ff;
        nxt_dout       = dout_ff;
        nxt_doe        = doe_ff;
        nxt_idx        = idx_ff;
        nxt_resp_valid = 1'b0;
        tmr_load       = 1'b0;
        tmr_value      = strobe_len;
        case (state_ff)
            ST_POWERUP: begin
                if (tmr_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmd_valid) begin
                    nxt_cmd = cmd;
                    nxt_idx = 3'h0;
                    if (refuse) begin
                        nxt_resp_valid = 1'b1;
                        nxt_resp.err   = 1'b1;
                    end else begin
                        nxt_addr  = start_addr;
                        nxt_ctl   = setup_pins(cmd.op);
                        nxt_dout  = cmd.wdata;
                        nxt_doe   = (cmd.op == nvsram_host_pkg::OP_WRITE);
                        nxt_state = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                nxt_ctl   = strobe_pins(cur_op);
                tmr_load  = 1'b1;
                nxt_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (tmr_done) begin
                    nxt_ctl       = nvsram_host_pkg::PINS_IDLE;
                    nxt_resp.err  = 1'b0;
                    nxt_resp.rdata = din_sync_ff;
                    nxt_state     = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (seq_more) begin
                    nxt_idx   = idx_ff + 3'h1;
                    nxt_addr  = next_seq_addr;
                    nxt_state = ST_SETUP;
                end else if (nv_op) begin
                    tmr_load  = 1'b1;
                    tmr_value = nv_len;
                    nxt_state = ST_NV_WAIT;
                end else begin
                    nxt_doe        = 1'b0;
                    nxt_resp_valid = 1'b1;
                    nxt_state      = ST_IDLE;
                end
            end
            ST_NV_WAIT: begin
                if (tmr_done) begin
                    nxt_resp_valid = 1'b1;
                    nxt_state      = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            din_meta_ff <= nvsram_host_pkg::DATA_RESET;
            din_sync_ff <= nvsram_host_pkg::DATA_RESET;
            low_meta_ff <= 1'b1;
            low_sync_ff <= 1'b1;
        end else if (ce) begin
            din_meta_ff <= data_lines_in;
            din_sync_ff <= din_meta_ff;
            low_meta_ff <= supply_low;
            low_sync_ff <= low_meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff      <= ST_POWERUP;
            cmd_ff        <= '0;
            ctl_ff        <= nvsram_host_pkg::PINS_IDLE;
            resp_ff       <= '0;
            addr_ff       <= nvsram_host_pkg::ADDR_RESET;
            dout_ff       <= nvsram_host_pkg::DATA_RESET;
            doe_ff        <= 1'b0;
            resp_valid_ff <= 1'b0;
            idx_ff        <= 3'h0;
        end else if (ce) begin
            state_ff      <= nxt_state;
            cmd_ff        <= nxt_cmd;
            ctl_ff        <= nxt_ctl;
            resp_ff       <= nxt_resp;
            addr_ff       <= nxt_addr;
            dout_ff       <= nxt_dout;
            doe_ff        <= nxt_doe;
            resp_valid_ff <= nxt_resp_valid;
            idx_ff        <= nxt_idx;
        end
    end

    nv_cycle_timer i_nv_cycle_timer (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .load       (tmr_load && ce),
        .load_value (tmr_value),
        .done       (tmr_done)
    );

    assign cmd_ready      = (state_ff == ST_IDLE) && ce;
    assign resp_valid     = resp_valid_ff;
    assign resp           = resp_ff;
    assign pins           = ctl_ff;
    assign address_lines  = addr_ff;
    assign data_lines_out = dout_ff;
    assign data_lines_oe  = doe_ff;

    sequence s_enter_nv;
        (state_ff != ST_NV_WAIT) ##1 (state_ff == ST_NV_WAIT);
    endsequence

    property p_seq_we_high;
        @(posedge clk) disable iff (rst)
        (cur_sw && state_ff != ST_IDLE && state_ff != ST_POWERUP) |-> ctl_ff.write_en_low;
    endproperty
    a_seq_we_high: assert property (p_seq_we_high)
        else $error("write enable low during software sequence");

    property p_seq_addr;
        @(posedge clk) disable iff (rst)
        (cur_sw && state_ff == ST_STROBE) |->
            address_lines == nvsram_host_pkg::seq_addr(idx_ff, cur_rcl);
    endproperty
    a_seq_addr: assert property (p_seq_addr)
        else $error("sequence read at wrong address");

    property p_seq_step;
        @(posedge clk) disable iff (rst)
        (idx_ff != $past(idx_ff)) |-> (idx_ff == $past(idx_ff) + 3'h1) || (idx_ff == 3'h0);
    endproperty
    a_seq_step: assert property (p_seq_step)
        else $error("sequence step skipped");

    property p_nv_after_six;
        @(posedge clk) disable iff (rst)
        s_enter_nv |-> (!cur_sw || idx_ff == 3'(nvsram_host_pkg::SEQ_LAST));
    endproperty
    a_nv_after_six: assert property (p_nv_after_six)
        else $error("nonvolatile wait before sixth read");

    property p_write_oe_high;
        @(posedge clk) disable iff (rst)
        (!ctl_ff.write_en_low) |-> ctl_ff.out_en_low && !ctl_ff.chip_en_low;
    endproperty
    a_write_oe_high: assert property (p_write_oe_high)
        else $error("output enable low during write");

    property p_write_addr_stable;
        @(posedge clk) disable iff (rst)
        (cur_op == nvsram_host_pkg::OP_WRITE && state_ff == ST_STROBE) |=>
            $stable(address_lines) && data_lines_oe;
    endproperty
    a_write_addr_stable: assert property (p_write_addr_stable)
        else $error("address moved during write");

    property p_we_last;
        @(posedge clk) disable iff (rst)
        ($fell(ctl_ff.write_en_low) && cur_op == nvsram_host_pkg::OP_PIN_STORE) |->
            $past(!ctl_ff.chip_en_low && !ctl_ff.nonvolatile_trigger_low);
    endproperty
    a_we_last: assert property (p_we_last)
        else $error("write enable not last into store");

    property p_recall_addr_hold;
        @(posedge clk) disable iff (rst)
        (state_ff == ST_NV_WAIT) |=> $stable(address_lines);
    endproperty
    a_recall_addr_hold: assert property (p_recall_addr_hold)
        else $error("address changed during nonvolatile cycle");

    property p_store_refused;
        @(posedge clk) disable iff (rst)
        (cmd_ready && cmd_valid && nvsram_host_pkg::is_store(cmd.op) && low_sync_ff) |=>
            resp_valid && resp.err && state_ff == ST_IDLE;
    endproperty
    a_store_refused: assert property (p_store_refused)
        else $error("store started with supply low");

    property p_powerup_block;
        @(posedge clk) disable iff (rst)
        (state_ff == ST_POWERUP) |-> !cmd_ready && pins == nvsram_host_pkg::PINS_IDLE;
    endproperty
    a_powerup_block: assert property (p_powerup_block)
        else $error("access during power-up recall");
endmodule

// *** nvsram_host_pkg.sv ***
// Constants, types and helpers shared by the non-volatile SRAM host controller
package nvsram_host_pkg;

    localparam int ADDR_W        = 13;
    localparam int DATA_W        = 8;
    localparam int TIMER_W       = 19;
    localparam int SEQ_LAST      = 5;

    localparam int CLK_PERIOD_NS = 25;
    localparam int ACCESS_NS     = 45;
    localparam int STORE_MS      = 10;
    localparam int RECALL_US     = 20;
    localparam int RECALL_INIT_US = 25;
    localparam int SYNC_CYC      = 2;

    // Least times, rounded up to whole clock cycles
    localparam int PULSE_CYC       = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC        = PULSE_CYC + SYNC_CYC + 1;
    localparam int STORE_CYC       = (STORE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_CYC      = (RECALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_INIT_CYC =
        (RECALL_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC     = RECALL_CYC;

    localparam logic [ADDR_W-1:0] SEQ_ADDR_0      = 13'h0000;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_1      = 13'h1555;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_2      = 13'h0AAA;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_3      = 13'h1FFF;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_4      = 13'h10F0;
    localparam logic [ADDR_W-1:0] SEQ_STORE_LAST  = 13'h0F0F;
    localparam logic [ADDR_W-1:0] SEQ_RECALL_LAST = 13'h0F0E;
    localparam logic [ADDR_W-1:0] ADDR_RESET      = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET      = 8'h00;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_SW_STORE,
        OP_SW_RECALL,
        OP_PIN_STORE,
        OP_PIN_RECALL
    } op_type;

    typedef struct packed {
        op_type              op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } cmd_type;

    typedef struct packed {
        logic                err;
        logic [DATA_W-1:0]   rdata;
    } resp_type;

    // Pin levels as driven; 1 means the active-low pin is inactive
    typedef struct packed {
        logic chip_en_low;
        logic out_en_low;
        logic write_en_low;
        logic nonvolatile_trigger_low;
    } ctl_pins_type;

    localparam ctl_pins_type PINS_IDLE = 4'hF;

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                   input logic       recall);
        case (idx)
            3'h0:    seq_addr = SEQ_ADDR_0;
            3'h1:    seq_addr = SEQ_ADDR_1;
            3'h2:    seq_addr = SEQ_ADDR_2;
            3'h3:    seq_addr = SEQ_ADDR_3;
            3'h4:    seq_addr = SEQ_ADDR_4;
            default: seq_addr = recall ? SEQ_RECALL_LAST : SEQ_STORE_LAST;
        endcase
    endfunction

    function automatic logic is_store(input op_type op);
        is_store = (op == OP_SW_STORE) || (op == OP_PIN_STORE);
    endfunction

    function automatic logic is_sw(input op_type op);
        is_sw = (op == OP_SW_STORE) || (op == OP_SW_RECALL);
    endfunction

endpackage

// *** nv_cycle_timer.sv ***
// Down counter that times strobes, non-volatile cycles and the power-up wait
`timescale 1ns/1ps
module nv_cycle_timer (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    input  wire logic                                 ce,
    input  wire logic                                 load,
    input  wire logic [nvsram_host_pkg::TIMER_W-1:0]  load_value,
    output logic                                      done
);
    logic [nvsram_host_pkg::TIMER_W-1:0] count_ff;

    // Reset starts the power-up recall wait at once
    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff <= nvsram_host_pkg::TIMER_W'(nvsram_host_pkg::POWERUP_CYC - 1);
        end else if (ce) begin
            if (load) begin
                count_ff <= load_value;
            end else if (count_ff != '0) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    assign done = (count_ff == '0) && !load;
endmodule

// *** nvsram_dev_model.sv ***
// Behavioural model of the 8K x 8 non-volatile SRAM as seen from its pins
`timescale 1ns/1ps
module nvsram_dev_model #(
    parameter int STORE_NS  = 400,
    parameter int RECALL_NS = 20000
) (
    input  wire logic                          hw_variant,
    input  wire nvsram_host_pkg::ctl_pins_type pins,
    input  wire logic [12:0]                   address_lines,
    input  wire logic [7:0]                    host_dq,
    input  wire logic                          supply_low,
    output logic [7:0]                         dev_dq
);
    localparam logic [12:0] SEQ [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
    logic [7:0]  sram [8192];
    logic [7:0]  shadow [8192];
    logic [7:0]  last_dq;
    logic [12:0] wr_addr;
    logic [7:0]  wr_data;
    logic        busy;
    logic        armed;
    logic        wr_pend;
    int          step;

    wire rd_cond = !busy && !pins.chip_en_low && !pins.out_en_low && pins.write_en_low
                   && pins.nonvolatile_trigger_low;
    // Undriven bus shows the inverse of the last value, not a convenient hold
    assign dev_dq = rd_cond ? sram[address_lines] : ~last_dq;
    always @(dev_dq or rd_cond) if (rd_cond) last_dq = dev_dq;

    task automatic do_recall;
        busy = 1'b1;
        for (int i = 0; i < 8192; i++) begin
            sram[i] = 8'h00;
            sram[i] = shadow[i];
        end
        #(RECALL_NS);
        busy = 1'b0;
    endtask

    task automatic do_store;
        if (!supply_low) begin
            busy = 1'b1;
            for (int i = 0; i < 8192; i++) shadow[i] = 8'hFF;
            #(STORE_NS);
            // Supply lost mid-store leaves the shadow erased
            if (!supply_low) for (int i = 0; i < 8192; i++) shadow[i] = sram[i];
            busy = 1'b0;
        end
    endtask

    initial begin
        last_dq = 8'h00;
        armed   = 1'b0;
        wr_pend = 1'b0;
        step    = 0;
        for (int i = 0; i < 8192; i++) shadow[i] = 8'hFF;
        do_recall;
    end

    always @(negedge pins.chip_en_low) begin
        if (!hw_variant && !busy && pins.nonvolatile_trigger_low) begin
            if (!pins.write_en_low) step = 0;
            else if (step == 5 && (address_lines == 13'h0F0F || address_lines == 13'h0F0E)) begin
                step = 0;
                if (address_lines[0]) do_store;
                else do_recall;
            end else if (step < 5 && address_lines == SEQ[step]) step++;
            else if (address_lines != 13'h0000) step = 0;
        end
    end

    always @(negedge pins.nonvolatile_trigger_low) armed = 1'b1;

    always @(pins) begin
        if (hw_variant && !busy && armed && !pins.nonvolatile_trigger_low && !pins.chip_en_low) begin
            if (!pins.write_en_low && pins.out_en_low) begin
                armed = 1'b0;
                do_store;
            end else if (pins.write_en_low && !pins.out_en_low) begin
                armed = 1'b0;
                do_recall;
            end
        end
    end

    always @(pins or address_lines or host_dq) begin
        if (!busy && !pins.chip_en_low && !pins.write_en_low && pins.nonvolatile_trigger_low) begin
            wr_pend = 1'b1;
            wr_addr = address_lines;
            wr_data = host_dq;
        end else if (wr_pend) begin
            wr_pend = 1'b0;
            sram[wr_addr] = wr_data;
        end
    end
endmodule

// *** nvsram_host_bench.sv ***
// Self-checking bench for the non-volatile SRAM host controller
`timescale 1ns/1ps
module nvsram_host_bench;
    localparam int STORE_WAIT = 20;
    logic                          clk;
    logic                          rst;
    logic                          ce;
    logic                          hw_variant;
    logic                          cmd_valid;
    logic                          supply_low;
    logic                          cmd_ready;
    logic                          resp_valid;
    logic                          data_lines_oe;
    logic                          wr_ff;
    logic                          busy_ff;
    logic [12:0]                   wr_addr_ff;
    logic [12:0]                   address_lines;
    logic [7:0]                    data_lines_out;
    logic [7:0]                    dev_dq;
    nvsram_host_pkg::cmd_type      cmd;
    nvsram_host_pkg::resp_type     resp;
    nvsram_host_pkg::resp_type     rsp;
    nvsram_host_pkg::ctl_pins_type pins;
    int                            n_errors;
    int                            num_checks;
    wire [7:0] data_lines_in = data_lines_oe ? data_lines_out : dev_dq;

    nvsram_host #(.STORE_WAIT_CYC(STORE_WAIT)) i_nvsram_host (
        .clk(clk), .rst(rst), .ce(ce), .hw_variant(hw_variant), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp),
        .pins(pins), .address_lines(address_lines), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in),
        .supply_low(supply_low));

    // Model store finishes just inside the host's shortened wait
    nvsram_dev_model #(.STORE_NS(STORE_WAIT * 25 - 100), .RECALL_NS(20000)) i_nvsram_dev_model (
        .hw_variant(hw_variant), .pins(pins), .address_lines(address_lines),
        .host_dq(data_lines_in), .supply_low(supply_low), .dev_dq(dev_dq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic run_op(input nvsram_host_pkg::op_type op, input logic [12:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd = '{op: op, addr: a, wdata: d};
        @(negedge clk);
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk("response seen", 8'h01, {7'h00, resp_valid});
        rsp = resp;
    endtask

    // Host must never enable outputs or move the address inside a write
    always @(posedge clk) begin
        if (!rst && pins.write_en_low === 1'b0) begin
            if (pins.out_en_low !== 1'b1) begin
                n_errors++;
                $display("CHECK FAILED out_en_low in write expected 1 seen %b", pins.out_en_low);
            end
            if (wr_ff && address_lines !== wr_addr_ff) begin
                n_errors++;
                $display("CHECK FAILED write address expected %h seen %h", wr_addr_ff, address_lines);
            end
        end
        // Address must hold while the part runs a nonvolatile cycle
        if (!rst && busy_ff && address_lines !== wr_addr_ff) begin
            n_errors++;
            $display("CHECK FAILED busy address expected %h seen %h", wr_addr_ff, address_lines);
        end
        wr_ff <= (pins.write_en_low === 1'b0);
        busy_ff <= (i_nvsram_dev_model.busy === 1'b1);
        wr_addr_ff <= address_lines;
    end

    task automatic t_powerup;
        int n;
        n = 0;
        repeat (700) @(negedge clk);
        chk("ready during power-up", 8'h00, {7'h00, cmd_ready});
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("ready after power-up", 8'h01, {7'h00, cmd_ready});
    endtask

    task automatic t_rw;
        run_op(nvsram_host_pkg::OP_WRITE, 13'h0123, 8'hA5);
        chk("write err", 8'h00, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_WRITE, 13'h1FFF, 8'h3C);
        run_op(nvsram_host_pkg::OP_READ, 13'h0123, 8'h00);
        chk("read low byte", 8'hA5, rsp.rdata);
        run_op(nvsram_host_pkg::OP_READ, 13'h1FFF, 8'h00);
        chk("read top byte", 8'h3C, rsp.rdata);
    endtask

    task automatic t_sw_nv;
        hw_variant = 1'b0;
        run_op(nvsram_host_pkg::OP_WRITE, 13'h0040, 8'h5A);
        run_op(nvsram_host_pkg::OP_SW_STORE, 13'h0000, 8'h00);
        chk("sw store err", 8'h00, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_WRITE, 13'h0040, 8'h00);
        run_op(nvsram_host_pkg::OP_READ, 13'h0040, 8'h00);
        chk("overwritten byte", 8'h00, rsp.rdata);
        run_op(nvsram_host_pkg::OP_SW_RECALL, 13'h0000, 8'h00);
        chk("sw recall err", 8'h00, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_READ, 13'h0040, 8'h00);
        chk("recalled byte", 8'h5A, rsp.rdata);
    endtask

    task automatic t_refuse;
        supply_low = 1'b1;
        repeat (4) @(negedge clk);
        run_op(nvsram_host_pkg::OP_SW_STORE, 13'h0000, 8'h00);
        chk("store on low supply", 8'h01, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_SW_RECALL, 13'h0000, 8'h00);
        chk("recall on low supply", 8'h00, {7'h00, rsp.err});
        supply_low = 1'b0;
        repeat (4) @(negedge clk);
        run_op(nvsram_host_pkg::OP_PIN_STORE, 13'h0000, 8'h00);
        chk("pin op on sw part", 8'h01, {7'h00, rsp.err});
    endtask

    task automatic t_pin;
        hw_variant = 1'b1;
        run_op(nvsram_host_pkg::OP_SW_STORE, 13'h0000, 8'h00);
        chk("sw op on pin part", 8'h01, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_WRITE, 13'h0777, 8'hC3);
        run_op(nvsram_host_pkg::OP_PIN_STORE, 13'h0000, 8'h00);
        chk("pin store err", 8'h00, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_WRITE, 13'h0777, 8'h11);
        run_op(nvsram_host_pkg::OP_PIN_RECALL, 13'h0000, 8'h00);
        chk("pin recall err", 8'h00, {7'h00, rsp.err});
        run_op(nvsram_host_pkg::OP_READ, 13'h0777, 8'h00);
        chk("pin recalled byte", 8'hC3, rsp.rdata);
    endtask

    // Whole run is about 4500 cycles; this allows more than three times that
    initial begin
        #400000;
        n_errors++;
        $display("CHECK FAILED watchdog expected done seen running");
        finish_test;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hw_variant = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        supply_low = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (20) @(negedge clk);
        chk("pins in reset", 8'h0F, {4'h0, pins});
        chk("data oe in reset", 8'h00, {7'h00, data_lines_oe});
        rst = 1'b0;
        t_powerup;
        t_rw;
        t_sw_nv;
        t_refuse;
        t_pin;
        finish_test;
    end
endmodule
